// *** src/adc_ctrl_pkg.sv ***
// Package: register map, field layout and timing constants of the converter control block
package adc_ctrl_pkg;

  // ***********************
  // Register byte addresses
  // ***********************
  localparam logic [7:0] OPER_CTRL_OFS = 8'h14;
  localparam logic [7:0] PORT_CFG_OFS = 8'h15;
  localparam logic [7:0] RESULT_HIGH_OFS = 8'h18;
  localparam logic [7:0] RESULT_LOW_OFS = 8'h1C;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h24;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h28;

  // *****************
  // Field positions
  // *****************
  localparam int POWER_BIT = 0;
  localparam int GO_BIT = 2;
  localparam int CHAN_LSB = 4;
  localparam int REFSEL_BIT = 0;
  localparam int PCFG_LSB = 1;
  localparam int JUSTIFY_BIT = 5;
  localparam int CLKSEL_LSB = 6;
  localparam logic [7:0] OPER_CTRL_MASK = 8'hF5;
  localparam logic [7:0] PORT_CFG_MASK = 8'hEF;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // *****************
  // Sizes
  // *****************
  localparam int RESULT_BITS = 10;
  localparam int CHANNELS_SMALL = 12;
  localparam int CHANNELS_LARGE = 16;
  localparam int CONV_PERIODS = 12;
  localparam logic [6:0] DIV_FOSC8 = 7'h08;
  localparam logic [6:0] DIV_FOSC32 = 7'h20;
  localparam logic [6:0] DIV_FOSC64 = 7'h40;
  localparam logic [1:0] CLKSEL_RC = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  // Analog front end control bundle
  typedef struct packed {
    logic power_on;
    logic hold;
    logic [3:0] channel;
    logic ref_pins;
    logic [15:0] analog_pins;
    logic [RESULT_BITS-1:0] dac_code;
  } afe_ctrl_t;

endpackage

// *** src/adc_sequencer_control.sv ***
// Converter control: registers, successive-approximation sequencer and interrupt
`timescale 1ns/100ps

// Function
// - Twelve or sixteen channels via channel field
// - Ten-bit result by successive approximation
// - Convert from held sample, not live pin
// - References selectable: supply rails or pins
// - Keep converting in sleep only with RC
// - Result high, low, control, port config registers
// - Port config selects analog pins and references
// - Completion loads result, clears start, flags
// - Conversion lasts twelve conversion clock periods
// - Clock select: divide 8, 32, 64, RC
// - Justify bit chooses right or left alignment
module adc_sequencer_control
  import adc_ctrl_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System state and RC conversion clock tick
  input wire logic cpu_sleep,
  input wire logic rc_clk_pin,
  // Analog front end
  input wire logic comparator_pin,
  output afe_ctrl_t afe_ctrl,
  // Interrupt
  output logic irq
);

  // *****************
  // Input synchronisers
  // *****************
  logic [1:0] cmp_sync_q;
  logic [2:0] rc_sync_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_sync_q <= 2'h0;
      rc_sync_q <= 3'h0;
    end else if (clk_en) begin
      cmp_sync_q <= {cmp_sync_q[0], comparator_pin};
      rc_sync_q <= {rc_sync_q[1:0], rc_clk_pin};
    end
  end
  wire logic cmp_above = cmp_sync_q[1];
  wire logic rc_tick = rc_sync_q[1] & ~rc_sync_q[2];

  // *****************
  // Registers
  // *****************
  logic [7:0] oper_q;
  logic [7:0] cfg_q;
  logic [RESULT_BITS-1:0] result_q;
  logic status_q;
  logic enable_q;
  logic [1:0] ack_q;
  conv_state_t state_q;
  logic [RESULT_BITS-1:0] sar_q;
  logic [3:0] bit_q;
  logic [3:0] period_q;
  logic [6:0] div_q;
  logic [15:0] analog_map;

  wire logic power_on = oper_q[POWER_BIT];
  wire logic [3:0] chan_sel = oper_q[CHAN_LSB +: 4];
  wire logic [1:0] clk_sel = cfg_q[CLKSEL_LSB +: 2];
  wire logic right_just = cfg_q[JUSTIFY_BIT];

  // Access completes one cycle after it is seen, so waitrequest is low in the second cycle
  wire logic bus_req = (avs_read | avs_write) & ~ack_q[0];
  wire logic wr_take = avs_write & ack_q[0];
  wire logic sel_oper = (avs_address == OPER_CTRL_OFS);
  wire logic sel_cfg = (avs_address == PORT_CFG_OFS);
  wire logic sel_clr = (avs_address == IRQ_CLEAR_OFS);
  wire logic sel_en = (avs_address == IRQ_ENABLE_OFS);

  // Reserved codes on the small part fall back to channel zero
  wire logic chan_ok = LARGE_VARIANT || (chan_sel < 4'(CHANNELS_SMALL));
  wire logic [7:0] oper_wdata = avs_writedata[7:0] & OPER_CTRL_MASK;

  // Conversion clock: oscillator divide or RC tick
  wire logic [6:0] div_limit = (clk_sel == 2'h0) ? DIV_FOSC8 :
                               (clk_sel == 2'h1) ? DIV_FOSC32 : DIV_FOSC64;
  wire logic use_rc = (clk_sel == CLKSEL_RC);
  wire logic osc_tick = (div_q == div_limit - 7'h01);
  // In sleep the oscillator is stopped; only the RC clock keeps the sequence going
  wire logic period_tick = use_rc ? rc_tick : (osc_tick & ~cpu_sleep);
  wire logic go_write = wr_take & sel_oper & oper_wdata[GO_BIT];
  wire logic start = go_write & oper_wdata[POWER_BIT] & (state_q == ST_IDLE);
  wire logic last_period = period_tick & (period_q == 4'(CONV_PERIODS - 1));
  wire logic done = (state_q == ST_CONVERT) & last_period;
  // A repeated start during a conversion keeps the busy bit instead of dropping it
  wire logic go_hold = go_write & oper_wdata[POWER_BIT] & oper_q[GO_BIT] & ~done;
  wire logic [RESULT_BITS-1:0] trial = sar_q | (10'h001 << bit_q);
  wire logic [RESULT_BITS-1:0] kept = cmp_above ? trial : sar_q;

  // Result byte views
  wire logic [7:0] res_high = right_just ? {6'h00, result_q[9:8]} : result_q[9:2];
  wire logic [7:0] res_low = right_just ? result_q[7:0] : {result_q[1:0], 6'h00};

  wire logic [7:0] rd_byte = sel_oper ? oper_q :
                             sel_cfg ? cfg_q :
                             (avs_address == RESULT_HIGH_OFS) ? res_high :
                             (avs_address == RESULT_LOW_OFS) ? res_low :
                             (avs_address == IRQ_STATUS_OFS) ? {7'h00, status_q} :
                             sel_en ? {7'h00, enable_q} : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (clk_en) begin
      ack_q <= {1'b0, bus_req};
      avs_waitrequest <= ~bus_req;
      if (bus_req && avs_read) begin
        avs_readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // Operation control: software writes, hardware clears start bit and power gates it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oper_q <= CTRL_RESET;
      cfg_q <= CTRL_RESET;
      enable_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_take && sel_oper) begin
        oper_q <= {oper_wdata[7:3], start | go_hold, oper_wdata[1:0]};
      end else if (done || !power_on) begin
        oper_q[GO_BIT] <= 1'b0;
      end
      if (wr_take && sel_cfg) begin
        cfg_q <= avs_writedata[7:0] & PORT_CFG_MASK;
      end
      if (wr_take && sel_en) begin
        enable_q <= avs_writedata[0];
      end
    end
  end

  // Sequencer: sample period, then one period per bit, plus a settle period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      sar_q <= 10'h000;
      bit_q <= 4'h0;
      period_q <= 4'h0;
      div_q <= 7'h00;
      result_q <= 10'h000;
    end else if (clk_en) begin
      div_q <= (osc_tick || state_q == ST_IDLE) ? 7'h00 : div_q + 7'h01;
      if (!power_on && !start) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q <= ST_SAMPLE;
              period_q <= 4'h0;
              sar_q <= 10'h000;
              bit_q <= 4'(RESULT_BITS - 1);
            end
          end
          ST_SAMPLE: begin
            if (period_tick) begin
              state_q <= ST_CONVERT;
              period_q <= period_q + 4'h1;
            end
          end
          ST_CONVERT: begin
            if (period_tick) begin
              period_q <= period_q + 4'h1;
              if (period_q <= 4'(RESULT_BITS)) begin
                sar_q <= kept;
                bit_q <= bit_q - 4'h1;
              end
              if (last_period) begin
                state_q <= ST_IDLE;
                result_q <= sar_q;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Analog front end drive
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      afe_ctrl <= '0;
    end else if (clk_en) begin
      afe_ctrl.power_on <= power_on;
      afe_ctrl.hold <= (state_q == ST_CONVERT);
      afe_ctrl.channel <= chan_ok ? chan_sel : 4'h0;
      afe_ctrl.ref_pins <= cfg_q[REFSEL_BIT];
      afe_ctrl.analog_pins <= analog_map;
      afe_ctrl.dac_code <= (state_q == ST_CONVERT) ? trial : sar_q;
    end
  end

  // Analog pin map: channels at or above the cut in each half turn digital
  wire logic [2:0] pcfg = cfg_q[PCFG_LSB +: 3];
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS_LARGE; gi++) begin : g_pin
      assign analog_map[gi] = (pcfg != 3'h7) && (4'(gi % 8) < 4'(8 - pcfg)) &&
                              (LARGE_VARIANT || gi < CHANNELS_SMALL);
    end
  endgenerate

  // Interrupt: set wins over clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        status_q <= 1'b1;
      end else if (wr_take && sel_clr && avs_writedata[0]) begin
        status_q <= 1'b0;
      end
      irq <= (status_q | done) & enable_q;
    end
  end

  // *****************
  // Check helpers
  // *****************
  // Tally of conversion clock periods kept apart from the sequencer's own counter
  logic [3:0] conv_period_count_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      conv_period_count_q <= 4'h0;
    end else if (clk_en) begin
      if (start) begin
        conv_period_count_q <= 4'h0;
      end else if (period_tick && state_q != ST_IDLE && conv_period_count_q != 4'hF) begin
        conv_period_count_q <= conv_period_count_q + 4'h1;
      end
    end
  end

  // *****************
  // Checks
  // *****************
  AST_GO_CLEARS_ON_DONE: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && done |=> !oper_q[GO_BIT] && status_q) else $error("done did not clear start bit");
  AST_NO_START_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !power_on && state_q == ST_IDLE && !(wr_take && sel_oper) |=> state_q == ST_IDLE)
    else $error("conversion started while off");
  AST_POWER_OFF_IDLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !power_on && !start |=> state_q == ST_IDLE) else $error("sequencer active while off");
  AST_TAD_COUNT: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && done |-> conv_period_count_q == 4'(CONV_PERIODS - 1)) else $error("conversion length wrong");
  AST_RESULT_LOAD: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && done |=> result_q == $past(sar_q)) else $error("result not loaded");
  AST_RIGHT_JUST: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && bus_req && avs_read && avs_address == RESULT_HIGH_OFS && right_just
    |=> avs_readdata[7:2] == 6'h00) else $error("right justify high bits nonzero");
  AST_LEFT_JUST: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && bus_req && avs_read && avs_address == RESULT_LOW_OFS && !right_just
    |=> avs_readdata[5:0] == 6'h00) else $error("left justify low bits nonzero");
  AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
    oper_q[3] == 1'b0 && oper_q[1] == 1'b0) else $error("unimplemented bits set");
  AST_SLEEP_RC: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && cpu_sleep && !use_rc && state_q != ST_IDLE |=> period_q == $past(period_q))
    else $error("conversion clock ran in sleep");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_q == ST_CONVERT |=> afe_ctrl.hold) else $error("hold not asserted");
  AST_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && bus_req |=> !avs_waitrequest) else $error("access not answered in one cycle");
  AST_START_NEEDS_POWER: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && go_write && !oper_wdata[POWER_BIT] |=> !oper_q[GO_BIT] && state_q == ST_IDLE)
    else $error("start taken without power");
  AST_OFF_NO_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !power_on && !start ##1 clk_en |=> !afe_ctrl.hold)
    else $error("hold kept while off");
  AST_CHAN_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && chan_ok |=> afe_ctrl.channel == $past(chan_sel)) else $error("channel not selected");
  AST_IRQ_ENABLED: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && status_q && enable_q |=> irq) else $error("enabled status did not raise irq");
  AST_IRQ_MASKED: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !enable_q |=> !irq) else $error("masked status raised irq");

endmodule // adc_sequencer_control

// *** test/afe_model.sv ***
// Behavioural analog front end: per-channel level, track and hold, comparator
`timescale 1ns/100ps
module afe_model
  import adc_ctrl_pkg::*;
(
  // Control from the converter
  input wire logic sys_clk,
  input wire afe_ctrl_t afe_ctrl,
  // Bench level and comparator answer
  input wire logic [9:0] base_level,
  output logic comparator_pin
);
  logic [9:0] held_q;
  logic last_q = 1'b0;
  // Each channel sees its own level, so a wrong channel gives a wrong result
  wire [9:0] live_level = base_level ^ {afe_ctrl.channel, 6'h00};
  always_ff @(posedge sys_clk) begin
    if (!afe_ctrl.hold) held_q <= live_level;
    last_q <= comparator_pin;
  end
  // Outside hold the answer means nothing, so it toggles rather than lingering
  assign comparator_pin = (afe_ctrl.hold && afe_ctrl.power_on) ? (held_q >= afe_ctrl.dac_code) : ~last_q;
endmodule // afe_model

// *** test/testbench.sv ***
// Register-level bench for the converter control block
`timescale 1ns/100ps
module testbench
  import adc_ctrl_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic cpu_sleep = 1'b0, rc_clk_pin = 1'b0, clk_en = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, comparator_pin;
  afe_ctrl_t afe_ctrl;
  logic [9:0] base_level = 10'h2A5;
  logic [2:0] rc_cnt = 3'h0;
  logic [31:0] q;
  int errors = 0, checks_done = 0;

  adc_sequencer_control i_adc_sequencer_control (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_sleep(cpu_sleep),
    .rc_clk_pin(rc_clk_pin), .comparator_pin(comparator_pin), .afe_ctrl(afe_ctrl), .irq(irq));
  afe_model i_afe_model (.sys_clk(sys_clk), .afe_ctrl(afe_ctrl), .base_level(base_level),
    .comparator_pin(comparator_pin));

  initial forever #10 sys_clk = ~sys_clk;
  // RC period of ten cycles, distinct from every divider setting
  always @(posedge sys_clk) begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    if (rc_cnt == 3'h4) rc_clk_pin <= ~rc_clk_pin;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    bus(1'b0, a, 8'h00);
    chk(name, {24'h0, exp}, q);
  endtask

  // The interrupt is registered, so let one more edge land before looking
  task automatic irq_is(input logic exp, input string name);
    @(posedge sys_clk);
    chk(name, {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic wait_irq(ref int n);
    while (irq !== 1'b1 && n < 1500) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic test_done;
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("CHECK FAILED watchdog expected completion seen timeout");
    test_done();
  end

  initial begin
    int n;
    int div;
    logic [9:0] v;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OPER_CTRL_OFS, CTRL_RESET, "control reset");
    rd(PORT_CFG_OFS, 8'h00, "port config reset");
    bus(1'b1, OPER_CTRL_OFS, 8'hFE);
    rd(OPER_CTRL_OFS, 8'hF0, "control unimplemented bits");
    chk("power off", 0, afe_ctrl.power_on);
    chk("channel 15", 4'hF, afe_ctrl.channel);
    bus(1'b1, PORT_CFG_OFS, 8'hFF);
    rd(PORT_CFG_OFS, 8'hEF, "port config bit 4");
    chk("reference pins", 1, afe_ctrl.ref_pins);
    chk("analog pins off", 16'h0000, afe_ctrl.analog_pins);
    bus(1'b1, RESULT_HIGH_OFS, 8'hFF);
    rd(RESULT_HIGH_OFS, 8'h00, "result read only");
    bus(1'b1, 8'h30, 8'hFF);
    rd(8'h30, 8'h00, "unmapped");
    bus(1'b1, IRQ_ENABLE_OFS, 8'h01);
    for (int i = 0; i < 4; i++) begin
      div = (i == 0) ? 8 : (i == 1) ? 32 : (i == 2) ? 64 : 10;
      cpu_sleep <= (i == 3);
      v = base_level ^ {4'(i * 5), 6'h00};
      bus(1'b1, PORT_CFG_OFS, {2'(i), 1'(i), 5'h00});
      bus(1'b1, OPER_CTRL_OFS, {4'(i * 5), 4'h5});
      rd(OPER_CTRL_OFS, {4'(i * 5), 4'h5}, "start bit busy");
      chk("analog pins", 16'hFFFF, afe_ctrl.analog_pins);
      n = 0;
      while (afe_ctrl.hold !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        n++;
      end
      base_level <= ~base_level;
      wait_irq(n);
      chk("conversion length", 1, n >= 12 * div - 12 && n <= 12 * div + 12);
      rd(OPER_CTRL_OFS, {4'(i * 5), 4'h1}, "start bit cleared");
      rd(RESULT_HIGH_OFS, i[0] ? {6'h00, v[9:8]} : v[9:2], "result high");
      rd(RESULT_LOW_OFS, i[0] ? v[7:0] : {v[1:0], 6'h00}, "result low");
      rd(IRQ_STATUS_OFS, 8'h01, "status set");
      bus(1'b1, IRQ_ENABLE_OFS, 8'h00);
      irq_is(1'b0, "irq masked");
      bus(1'b1, IRQ_ENABLE_OFS, 8'h01);
      irq_is(1'b1, "irq unmasked");
      bus(1'b1, IRQ_CLEAR_OFS, 8'h01);
      irq_is(1'b0, "irq cleared");
      rd(IRQ_STATUS_OFS, 8'h00, "status cleared");
    end
    cpu_sleep <= 1'b0;
    bus(1'b1, PORT_CFG_OFS, 8'h06);
    bus(1'b1, OPER_CTRL_OFS, 8'h05);
    clk_en <= 1'b0;
    chk("analog pins partial", 16'h1F1F, afe_ctrl.analog_pins);
    repeat (150) @(posedge sys_clk);
    chk("clock enable freezes", 0, irq);
    clk_en <= 1'b1;
    n = 0;
    wait_irq(n);
    chk("resumes after freeze", 1, n >= 90 && n <= 100);
    bus(1'b1, IRQ_CLEAR_OFS, 8'h01);
    bus(1'b1, OPER_CTRL_OFS, 8'h05);
    repeat (20) @(posedge sys_clk);
    bus(1'b1, OPER_CTRL_OFS, 8'h00);
    repeat (150) @(posedge sys_clk);
    chk("power off mid conversion", 0, afe_ctrl.power_on);
    rd(IRQ_STATUS_OFS, 8'h00, "aborted conversion");
    cpu_sleep <= 1'b1;
    bus(1'b1, OPER_CTRL_OFS, 8'h05);
    repeat (200) @(posedge sys_clk);
    rd(OPER_CTRL_OFS, 8'h05, "sleep stalls divider");
    cpu_sleep <= 1'b0;
    n = 0;
    wait_irq(n);
    chk("resumes after sleep", 1, irq);
    test_done();
  end
endmodule // testbench
